/* File: tb_tuning_synth_divider_control.sv */
/*
 Self-checking bench of the tuning synthesizer control.
 Assumes tsd_top, tsd_pkg, tsd_regs.svh and tsd_host_model.
*/
`timescale 1ns/100ps
`include "tsd_regs.svh"
module tb_tuning_synth_divider_control;
    import tsd_pkg::*;
    logic hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ref_in = 1'b0, vco_in = 1'b0;
    logic ref_run = 1'b0, vco_run = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    tsd_word_t hwdata = 32'h0, hrdata, rd;
    logic hreadyout, hresp, ref_out_a, ref_out_b, ser_clk, ser_data, ser_en;
    logic data_check, pump_up_n, pump_down_n, lock_detect_n, synth_out, irq;
    logic [11:0] mword = 12'h000;
    // manual toggle below adds one reference rise
    int mismatches = 0, total_checks = 0, mn = 6000, ref_rises = 1, vco_rises = 0;
    int ph = 0, vph = 0, up_at = 0, dn_at = 0, n;

    tsd_top #(.LOCK_REFS(1)) tsd_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .ref_in(ref_in), .ref_out_a(ref_out_a), .ref_out_b(ref_out_b), .ser_clk(ser_clk),
        .ser_data(ser_data), .ser_en(ser_en), .data_check(data_check), .vco_in(vco_in),
        .pump_up_n(pump_up_n), .pump_down_n(pump_down_n), .lock_detect_n(lock_detect_n),
        .synth_out(synth_out), .irq(irq));
    tsd_host_model tsd_host_model_i (.hclk(hclk), .ser_clk(ser_clk), .ser_data(ser_data),
        .ser_en(ser_en));

    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    // ---------------------------------------------------------------
    // reference at 25 cycles, oscillator at 8 cycles
    // ---------------------------------------------------------------
    always @(posedge hclk) begin
        ph <= (ph == 24) ? 0 : ph + 1;
        vph <= (vph == 7) ? 0 : vph + 1;
        if (ref_run && ph == 0) ref_in <= 1'b1;
        if (ref_run && ph == 0) ref_rises <= ref_rises + 1;
        if (ref_run && ph == 12) ref_in <= 1'b0;
        if (vco_run && vph == 0) vco_in <= 1'b1;
        if (vco_run && vph == 0) vco_rises <= vco_rises + 1;
        if (vph == 4) vco_in <= 1'b0;
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic cmp_w(input string nm, input tsd_word_t e, input tsd_word_t g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp_b(input string nm, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic tmo(input int k, input int lim);
        if (k >= lim) begin
            mismatches++;
            print_verdict();
        end
    endtask

    task automatic ahb(input logic w, input logic [7:0] a, input tsd_word_t d);
        int k;
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= w;
        @(posedge hclk);
        for (k = 0; k < 50 && hreadyout !== 1'b1; k++) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        for (; k < 100 && hreadyout !== 1'b1; k++) @(posedge hclk);
        rd = hrdata;
        tmo(k, 50);
    endtask

    task automatic chk_status;
        ahb(1'b0, `TSD_STATUS_OFS, 32'h0);
        cmp_w("status", (32'(mn) << 16) | 32'(mword), rd);
    endtask

    task automatic send_word(input logic [11:0] w, input int nb, input logic ok);
        int k;
        tsd_host_model_i.send({4'h0, w}, nb);
        for (k = 0; k < 60 && data_check !== 1'b1; k++) @(posedge hclk);
        cmp_b("data_check", ok, data_check);
        if (ok) begin
            for (k = 0; k < 60 && data_check === 1'b1; k++) @(posedge hclk);
            cmp_w("check_width", 32'h28, k);
            mword = w;
            mn = 6000 - (w[11:8] * 100 + w[7:4] * 10 + w[3:0]);
        end
        chk_status();
        ahb(1'b0, `TSD_ISTAT_OFS, 32'h0);
        cmp_w("istat", ok ? 32'h2 : 32'h4, rd & 32'h6);
        ahb(1'b1, `TSD_IMASK_OFS, 32'h6);
        @(posedge hclk);
        cmp_b("irq_set", 1'b1, irq);
        ahb(1'b1, `TSD_ISTAT_OFS, 32'hF);
        @(posedge hclk);
        cmp_b("irq_clear", 1'b0, irq);
        ahb(1'b1, `TSD_IMASK_OFS, 32'h0);
    endtask

    initial begin
        void'($urandom(32'h5DD6079E));
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        cmp_b("pump_up_n", 1'b1, pump_up_n);
        cmp_b("pump_down_n", 1'b1, pump_down_n);
        cmp_b("lock_detect_n", 1'b1, lock_detect_n);
        cmp_b("hresp", 1'b0, hresp);
        ahb(1'b0, `TSD_CTRL_OFS, 32'h0);
        cmp_w("ctrl", 32'h00000001, rd);
        ahb(1'b0, `TSD_IMASK_OFS, 32'h0);
        cmp_w("imask", 32'h0, rd);
        ahb(1'b1, 8'h10, 32'hFFFFFFFF);
        ahb(1'b0, 8'h10, 32'h0);
        cmp_w("unmapped", 32'h0, rd);
        chk_status();
        for (int i = 0; i < 2; i++) begin
            ref_in <= ~ref_in;
            repeat (8) @(posedge hclk);
            cmp_b("ref_out_a", ref_in, ref_out_a);
            cmp_b("ref_out_b", ref_in, ref_out_b);
        end
        send_word({4'($urandom % 10), 4'($urandom % 10), 4'($urandom % 10)}, 12, 1'b1);
        send_word({4'hA, 4'($urandom % 10), 4'($urandom % 10)}, 12, 1'b0);
        send_word(12'h123, 11, 1'b0);
        send_word(12'h999, 12, 1'b1);
        // oscillator only: feedback leads
        vco_run <= 1'b1;
        // counter runs the reset ratio until its first wrap, new ratio after
        for (n = 0; n < 50000 && pump_down_n !== 1'b0; n++) begin
            @(posedge hclk);
            if (synth_out === 1'b1 && up_at == 0) up_at = vco_rises;
            if (synth_out === 1'b0 && up_at != 0 && dn_at == 0) dn_at = vco_rises;
        end
        tmo(n, 50000);
        cmp_w("fb_count", 32'd6000, vco_rises);
        cmp_b("pump_up_n", 1'b1, pump_up_n);
        cmp_w("synth_rise", 32'd500, up_at);
        cmp_w("synth_fall", 32'd1000, dn_at);
        cmp_b("lock_detect_n", 1'b1, lock_detect_n);
        // reference only: feedback lags
        vco_run <= 1'b0;
        ref_run <= 1'b1;
        for (n = 0; n < 5000 && pump_down_n !== 1'b1; n++) @(posedge hclk);
        tmo(n, 5000);
        cmp_w("ref_div", 32'd80, ref_rises);
        for (n = 0; n < 5000 && pump_up_n !== 1'b0; n++) @(posedge hclk);
        tmo(n, 5000);
        cmp_w("ref_div2", 32'd160, ref_rises);
        cmp_b("pump_down_n", 1'b1, pump_down_n);
        print_verdict();
    end
endmodule

/* File: tsd_host_model.sv */
/*
 Model of the host control board driving the serial tuning link.
 Assumes the block's hclk; link clock of 400 ns, still outside words.
*/
`timescale 1ns/100ps
module tsd_host_model (
    // clock
    input wire logic hclk,
    // serial link
    output logic ser_clk,
    output logic ser_data,
    output logic ser_en
);
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_en = 1'b0;
    end

    // ---------------------------------------------------------------
    // word transfer, msb first, data moved on clock fall
    // ---------------------------------------------------------------
    task automatic send(input logic [15:0] w, input int nb);
        ser_en <= 1'b1;
        repeat (4) @(posedge hclk);
        for (int i = nb - 1; i >= 0; i--) begin
            ser_data <= w[i];
            repeat (4) @(posedge hclk);
            ser_clk <= 1'b1;
            repeat (4) @(posedge hclk);
            ser_clk <= 1'b0;
        end
        // released data line shows the inverse
        ser_data <= ~w[0];
        repeat (4) @(posedge hclk);
        ser_en <= 1'b0;
        @(posedge hclk);
    endtask
endmodule

/* File: tsd_pkg.sv */
/*
 Types shared by the tuning synthesizer control.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package tsd_pkg;

    typedef logic [31:0] tsd_word_t;

    typedef enum logic [1:0] {
        TSD_SER_IDLE = 2'b01,
        TSD_SER_SHIFT = 2'b10
    } tsd_ser_state_t;

endpackage

/* File: tsd_regs.svh */
/*
 Register offsets, reset values and timing counts of the tuning synthesizer control.
 Assumes a 20 MHz hclk and a word-aligned AHB-Lite register window.
*/
`ifndef TSD_REGS_SVH
`define TSD_REGS_SVH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define TSD_CTRL_OFS 8'h00
`define TSD_STATUS_OFS 8'h04
`define TSD_ISTAT_OFS 8'h08
`define TSD_IMASK_OFS 8'h0C
`define TSD_CTRL_RST 32'h00000001
`define TSD_IMASK_RST 4'h0
`define TSD_CTRL_RUN_BIT 0
`define TSD_ST_LOCK_BIT 31
`define TSD_ST_N_LSB 16
`define TSD_IRQ_LOST_BIT 0
`define TSD_IRQ_WORD_BIT 1
`define TSD_IRQ_BAD_BIT 2
`define TSD_IRQ_GAIN_BIT 3

// ---------------------------------------------------------------
// divider ratios and tuning-word limits
// ---------------------------------------------------------------
`define TSD_DEC_DIV 4'd10
`define TSD_DEC_LAST (`TSD_DEC_DIV - 4'd1)
`define TSD_OCT_DIV 4'd8
`define TSD_OCT_LAST 3'((`TSD_OCT_DIV - 4'd1))
`define TSD_PRE_LO 4'd10
`define TSD_PRE_HI 4'd11
`define TSD_N_TOP 13'd6000
`define TSD_N_MIN 13'd5001
`define TSD_NC_TOP 10'((`TSD_N_TOP / 13'd10))
`define TSD_OUT_DIV 10'd1000
`define TSD_OUT_HALF ((`TSD_OUT_DIV / 10'd2) - 10'd1)
`define TSD_SER_BITS 4'd12
`define TSD_DIGIT_MAX 4'd9

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define TSD_CLK_NS 50
`define TSD_CHECK_NS 2000
`define TSD_CHECK_CYC 7'((`TSD_CHECK_NS + `TSD_CLK_NS - 1) / `TSD_CLK_NS)
`define TSD_LOCK_TOL_NS 500
`define TSD_LOCK_TOL_CYC 8'((`TSD_LOCK_TOL_NS / `TSD_CLK_NS))
`define TSD_LOCK_REFS 4

`endif

/* File: tsd_top.sv */
/*
 Digital side of the fine-tuning synthesizer: reference dividers, swallow-count
 feedback divider, phase/frequency comparator, lock detector, output divider,
 serial tuning-word receiver and an AHB-Lite register slave with interrupt.
 Assumes all pins are asynchronous to hclk and each toggles below hclk/4.

*/
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`include "tsd_regs.svh"

module tsd_top #(
    parameter int LOCK_REFS = `TSD_LOCK_REFS
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire tsd_pkg::tsd_word_t hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output tsd_pkg::tsd_word_t hrdata,
    // reference
    input wire logic ref_in,
    output logic ref_out_a,
    output logic ref_out_b,
    // host serial link
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_en,
    output logic data_check,
    // loop and interrupt
    input wire logic vco_in,
    output logic pump_up_n,
    output logic pump_down_n,
    output logic lock_detect_n,
    output logic synth_out,
    output logic irq
);
    import tsd_pkg::*;

    localparam int P_REF = 0;
    localparam int P_SCK = 1;
    localparam int P_SDA = 2;
    localparam int P_SEN = 3;
    localparam int P_VCO = 4;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [4:0] pin_s1, pin_s2, pin_s3, pin_rise, pin_fall;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1 <= 5'h00;
            pin_s2 <= 5'h00;
            pin_s3 <= 5'h00;
        end else begin
            pin_s1 <= {vco_in, ser_en, ser_data, ser_clk, ref_in};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end
    assign pin_rise = pin_s2 & ~pin_s3;
    assign pin_fall = ~pin_s2 & pin_s3;

    // ---------------------------------------------------------------
    // reference chain
    // ---------------------------------------------------------------
    logic [3:0] dec_cnt;
    logic [2:0] oct_cnt;
    logic ref80_tick, ref_tick;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_out_a <= 1'b0;
            ref_out_b <= 1'b0;
        end else begin
            ref_out_a <= pin_s2[P_REF];
            ref_out_b <= pin_s2[P_REF];
        end
    end

    assign ref80_tick = pin_rise[P_REF] && (dec_cnt == `TSD_DEC_LAST);
    assign ref_tick = ref80_tick && (oct_cnt == `TSD_OCT_LAST);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dec_cnt <= 4'h0;
            oct_cnt <= 3'h0;
        end else begin
            if (pin_rise[P_REF]) begin
                dec_cnt <= ref80_tick ? 4'h0 : dec_cnt + 4'h1;
            end
            if (ref80_tick) begin
                oct_cnt <= ref_tick ? 3'h0 : oct_cnt + 3'h1;
            end
        end
    end

    // ---------------------------------------------------------------
    // serial tuning-word receiver
    // ---------------------------------------------------------------
    tsd_ser_state_t ser_state;
    logic [11:0] shift_reg, tune_reg;
    logic [3:0] bit_cnt;
    logic word_end, word_good, word_bad;
    logic [9:0] tens_sum, nc_next, nc_reg;
    logic [3:0] a_next, a_reg;
    logic [12:0] n_next, n_reg;

    assign word_end = (ser_state == TSD_SER_SHIFT) && pin_fall[P_SEN];
    assign word_good = word_end && (bit_cnt == `TSD_SER_BITS)
        && (shift_reg[11:8] <= `TSD_DIGIT_MAX) && (shift_reg[7:4] <= `TSD_DIGIT_MAX)
        && (shift_reg[3:0] <= `TSD_DIGIT_MAX);
    assign word_bad = word_end && !word_good;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ser_state <= TSD_SER_IDLE;
            shift_reg <= 12'h000;
            bit_cnt <= 4'h0;
        end else begin
            case (ser_state)
                TSD_SER_IDLE: begin
                    if (pin_rise[P_SEN]) begin
                        ser_state <= TSD_SER_SHIFT;
                        bit_cnt <= 4'h0;
                    end
                end
                TSD_SER_SHIFT: begin
                    if (!pin_s2[P_SEN]) begin
                        ser_state <= TSD_SER_IDLE;
                    end else if (pin_rise[P_SCK]) begin
                        shift_reg <= {shift_reg[10:0], pin_s2[P_SDA]};
                        if (bit_cnt != 4'hF) begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                end
                default: ser_state <= TSD_SER_IDLE;
            endcase
        end
    end

    // ratio from the bcd digits: N = 10*nc + a with a prescaler cycles at /11
    always_comb begin
        tens_sum = 10'(shift_reg[11:8]) * 10'd10 + 10'(shift_reg[7:4]);
        n_next = `TSD_N_TOP - (13'(shift_reg[11:8]) * 13'd100
            + 13'(shift_reg[7:4]) * 13'd10 + 13'(shift_reg[3:0]));
        if (shift_reg[3:0] == 4'h0) begin
            nc_next = `TSD_NC_TOP - tens_sum;
            a_next = 4'h0;
        end else begin
            nc_next = `TSD_NC_TOP - 10'd1 - tens_sum;
            a_next = `TSD_PRE_LO - shift_reg[3:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tune_reg <= 12'h000;
            n_reg <= `TSD_N_TOP;
            nc_reg <= `TSD_NC_TOP;
            a_reg <= 4'h0;
        end else if (word_good) begin
            tune_reg <= shift_reg;
            n_reg <= n_next;
            nc_reg <= nc_next;
            a_reg <= a_next;
        end
    end

    // data-check pulse long enough for the host to sample
    logic [6:0] chk_cnt;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chk_cnt <= 7'h00;
            data_check <= 1'b0;
        end else if (word_good) begin
            chk_cnt <= `TSD_CHECK_CYC - 7'h01;
            data_check <= 1'b1;
        end else if (chk_cnt != 7'h00) begin
            chk_cnt <= chk_cnt - 7'h01;
        end else begin
            data_check <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // feedback divider: prescaler plus swallow counter
    // ---------------------------------------------------------------
    logic [3:0] pc_cnt, a_cnt, pc_last;
    logic [9:0] nc_cnt;
    logic presc_tick, fb_tick;

    assign pc_last = (a_cnt != 4'h0) ? `TSD_PRE_HI - 4'h1 : `TSD_PRE_LO - 4'h1;
    assign presc_tick = pin_rise[P_VCO] && (pc_cnt == pc_last);
    assign fb_tick = presc_tick && (nc_cnt == 10'h001);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_cnt <= 4'h0;
            nc_cnt <= `TSD_NC_TOP;
            a_cnt <= 4'h0;
        end else if (pin_rise[P_VCO]) begin
            pc_cnt <= presc_tick ? 4'h0 : pc_cnt + 4'h1;
            if (fb_tick) begin
                nc_cnt <= nc_reg;
                a_cnt <= a_reg;
            end else if (presc_tick) begin
                nc_cnt <= nc_cnt - 10'h001;
                if (a_cnt != 4'h0) begin
                    a_cnt <= a_cnt - 4'h1;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // phase/frequency comparator
    // ---------------------------------------------------------------
    logic run, up_set, dn_set;
    tsd_word_t ctrl_reg;

    assign run = ctrl_reg[`TSD_CTRL_RUN_BIT];
    assign up_set = !pump_up_n || ref_tick;
    assign dn_set = !pump_down_n || fb_tick;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pump_up_n <= 1'b1;
            pump_down_n <= 1'b1;
        end else if (!run || (up_set && dn_set)) begin
            pump_up_n <= 1'b1;
            pump_down_n <= 1'b1;
        end else begin
            pump_up_n <= !up_set;
            pump_down_n <= !dn_set;
        end
    end

    // ---------------------------------------------------------------
    // lock detector
    // ---------------------------------------------------------------
    logic [7:0] pw_cnt, good_cnt;
    logic lock_reg, wide;

    assign wide = (pw_cnt >= `TSD_LOCK_TOL_CYC);
    assign lock_detect_n = !lock_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pw_cnt <= 8'h00;
            good_cnt <= 8'h00;
            lock_reg <= 1'b0;
        end else begin
            if (pump_up_n && pump_down_n) begin
                pw_cnt <= 8'h00;
            end else if (!wide) begin
                pw_cnt <= pw_cnt + 8'h01;
            end
            if (!run || wide) begin
                good_cnt <= 8'h00;
                lock_reg <= 1'b0;
            end else if (ref_tick) begin
                if (good_cnt >= 8'(LOCK_REFS - 1)) begin
                    lock_reg <= 1'b1;
                end else begin
                    good_cnt <= good_cnt + 8'h01;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // output divider
    // ---------------------------------------------------------------
    logic [9:0] out_cnt;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_cnt <= 10'h000;
            synth_out <= 1'b0;
        end else if (pin_rise[P_VCO]) begin
            out_cnt <= (out_cnt == `TSD_OUT_DIV - 10'h001) ? 10'h000 : out_cnt + 10'h001;
            if (out_cnt == `TSD_OUT_HALF || out_cnt == `TSD_OUT_DIV - 10'h001) begin
                synth_out <= !synth_out;
            end
        end
    end

    // ---------------------------------------------------------------
    // ahb-lite slave and interrupt
    // ---------------------------------------------------------------
    logic ahb_go, wr_q, lock_q;
    logic [7:0] addr_q;
    logic [3:0] istat_reg, imask_reg, ev_set, ev_clr;

    assign ahb_go = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irq = |(istat_reg & imask_reg);
    assign ev_clr = (wr_q && addr_q == `TSD_ISTAT_OFS) ? hwdata[3:0] : 4'h0;

    always_comb begin
        ev_set = 4'h0;
        ev_set[`TSD_IRQ_LOST_BIT] = lock_q && !lock_reg;
        ev_set[`TSD_IRQ_WORD_BIT] = word_good;
        ev_set[`TSD_IRQ_BAD_BIT] = word_bad;
        ev_set[`TSD_IRQ_GAIN_BIT] = !lock_q && lock_reg;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wr_q <= ahb_go && hwrite;
            addr_q <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= `TSD_CTRL_RST;
            imask_reg <= `TSD_IMASK_RST;
            istat_reg <= 4'h0;
            lock_q <= 1'b0;
        end else begin
            lock_q <= lock_reg;
            if (wr_q && addr_q == `TSD_CTRL_OFS) begin
                ctrl_reg <= {31'h00000000, hwdata[`TSD_CTRL_RUN_BIT]};
            end
            if (wr_q && addr_q == `TSD_IMASK_OFS) begin
                imask_reg <= hwdata[3:0];
            end
            istat_reg <= (istat_reg & ~ev_clr) | ev_set;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (ahb_go && !hwrite) begin
            case (haddr[7:0])
                `TSD_CTRL_OFS: hrdata <= ctrl_reg;
                `TSD_STATUS_OFS: hrdata <= {lock_reg, 2'h0, n_reg, 4'h0, tune_reg};
                `TSD_ISTAT_OFS: hrdata <= {28'h0000000, istat_reg};
                `TSD_IMASK_OFS: hrdata <= {28'h0000000, imask_reg};
                default: hrdata <= 32'h00000000;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    AST_REF_COPY: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 (ref_out_a == ref_out_b) && (ref_out_a == $past(pin_s2[P_REF])))
        else $error("reference copies differ from reference input");

    AST_DECADE: assert property (@(posedge hclk) disable iff (!hresetn)
        ref80_tick |-> pin_rise[P_REF] && dec_cnt == 4'd9 ##1 dec_cnt == 4'd0)
        else $error("decade divider wrapped at the wrong count");

    AST_REF10: assert property (@(posedge hclk) disable iff (!hresetn)
        ref_tick |-> ref80_tick && oct_cnt == 3'd7 ##1 oct_cnt == 3'd0)
        else $error("comparison reference not every eighth 80 kHz tick");

    AST_PRESC: assert property (@(posedge hclk) disable iff (!hresetn)
        presc_tick |-> pc_cnt == ((a_cnt != 4'h0) ? 4'd10 : 4'd9))
        else $error("prescaler modulus not matched to swallow count");

    AST_NRANGE: assert property (@(posedge hclk) disable iff (!hresetn)
        n_reg >= 13'd5001 && n_reg <= 13'd6000
        && n_reg == 13'(nc_reg) * 13'd10 + 13'(a_reg))
        else $error("division ratio out of range or inconsistent");

    AST_NFORM: assert property (@(posedge hclk) disable iff (!hresetn)
        word_good |=> n_reg == 13'd6000 - (13'($past(shift_reg[11:8])) * 13'd100
        + 13'($past(shift_reg[7:4])) * 13'd10 + 13'($past(shift_reg[3:0]))))
        else $error("ratio not 6000 minus tuning value");

    AST_SHIFT_EN: assert property (@(posedge hclk) disable iff (!hresetn)
        !pin_s2[P_SEN] |=> $stable(bit_cnt) || bit_cnt == 4'h0)
        else $error("bit accepted while enable low");

    AST_MATCH: assert property (@(posedge hclk) disable iff (!hresetn)
        ref_tick && fb_tick && pump_up_n && pump_down_n |=> pump_up_n && pump_down_n)
        else $error("pulse emitted on matched edges");

    AST_UP: assert property (@(posedge hclk) disable iff (!hresetn)
        run && ref_tick && !fb_tick && pump_down_n |=> !pump_up_n && pump_down_n)
        else $error("lagging feedback did not pulse pump-up alone");

    AST_DOWN: assert property (@(posedge hclk) disable iff (!hresetn)
        run && fb_tick && !ref_tick && pump_up_n |=> !pump_down_n && pump_up_n)
        else $error("leading feedback did not pulse pump-down alone");

    AST_EXCL: assert property (@(posedge hclk) disable iff (!hresetn)
        !(!pump_up_n && !pump_down_n))
        else $error("both pump outputs low together");

    AST_OUTDIV: assert property (@(posedge hclk) disable iff (!hresetn)
        synth_out != $past(synth_out) |-> $past(pin_rise[P_VCO])
        && ($past(out_cnt) == 10'd499 || $past(out_cnt) == 10'd999))
        else $error("output toggled off the divide-by-1000 points");

    AST_UNLOCK: assert property (@(posedge hclk) disable iff (!hresetn)
        wide |=> lock_detect_n)
        else $error("lock detect low during wide correction pulse");

    AST_CHECK: assert property (@(posedge hclk) disable iff (!hresetn)
        word_good |=> data_check [*8])
        else $error("data-check pulse missing after good word");

    COV_WORD: cover property (@(posedge hclk) disable iff (!hresetn) word_good);
    COV_BAD: cover property (@(posedge hclk) disable iff (!hresetn) word_bad);
    COV_LOCK: cover property (@(posedge hclk) disable iff (!hresetn) $rose(lock_reg));
    COV_UP: cover property (@(posedge hclk) disable iff (!hresetn) $fell(pump_up_n));
endmodule
